// ===== hw/kpus_pkg.sv
// Purpose: shared constants of the key power-up sequencer
// Assumes: 100 MHz system clock, internal oscillator tick derived from it
// Notes:   times are kept in their printed units, cycle counts derived here
package kpus_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned OSC_DIV         = 100;           // 1 MHz oscillator tick
  localparam int unsigned OSC_HZ          = CLK_HZ / OSC_DIV;
  localparam int unsigned KEY_FILT_US     = 16_000;        // key filter time, typ
  localparam int unsigned REG_DELAY_US    = 1_000;         // regulator start delay
  localparam int unsigned RAIL33_DELAY_US = 1_000;         // 3.3 V delay, 1.0 ms
  localparam int unsigned OV_FILT_US      = 1_000;         // overvoltage filter
  localparam int unsigned US_PER_S        = 1_000_000;
  localparam int unsigned KEY_FILT_TICKS  = KEY_FILT_US * (OSC_HZ / US_PER_S);
  localparam int unsigned REG_DELAY_TICKS = REG_DELAY_US * (OSC_HZ / US_PER_S);
  localparam int unsigned RAIL33_TICKS    = RAIL33_DELAY_US * (OSC_HZ / US_PER_S);
  localparam int unsigned OV_FILT_TICKS   = OV_FILT_US * (OSC_HZ / US_PER_S);
  localparam int unsigned CNT_W           = 16;
endpackage : kpus_pkg

// ===== hw/kpus_filter.sv
// Purpose: qualify a level: output high once input held for a tick count
// Assumes: tick is a one-cycle enable; input already synchronised
// Notes:   count restarts whenever the input drops
`timescale 1ns/100ps
module kpus_filter #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_tick,
  input  wire logic             i_level,
  input  wire logic [CNT_W-1:0] i_limit,
  output logic                  o_qual
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             qual_reg;
  logic             qual_next;

  // count ticks while level holds, clear on drop
  always_comb begin
    cnt_next  = cnt_reg;
    qual_next = qual_reg;
    if (!i_level) begin
      cnt_next  = '0;
      qual_next = 1'b0;
    end else if (i_tick && !qual_reg) begin
      if (cnt_reg >= i_limit - 1'b1) qual_next = 1'b1;
      else cnt_next = cnt_reg + 1'b1;
    end
  end

  // register count and qualified flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg  <= '0;
      qual_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      qual_reg <= qual_next;
    end
  end

  assign o_qual = qual_reg;
endmodule : kpus_filter

// ===== hw/kpus_sequencer.sv
// Purpose: power-up sequencing from ignition key to regulator enables
// Assumes: comparator outputs arrive asynchronously and are synchronised
// Notes:   latch timeout generation is external; overvoltage shutdown and power-down on loss of enable are here
//
// What this block does
// - switch on relay and rails only after key stays high for the full filter time
// - non-permanent supply: first turn on the main relay drive
// - filter, relay drive and oscillator run from key-pin supply alone
// - enable internal bias once battery pin clears rising undervoltage threshold
// - enable five volt rail one regulator delay after bias enable
// - enable three volt rail about 1.0 ms after five volt rail is good
// - sensor tracking supplies enable together with five volt rail
// - permanent supply: enable bias directly when key exceeds high threshold
// - permanent supply: five volt rail one regulator delay after key filter
// - switch off when battery overvoltage lasts longer than its filter time
// - internal enable: not undervoltage and (key or unexpired latch-hold)
`timescale 1ns/100ps
module kpus_sequencer #(
  parameter int unsigned KEY_FILT_TICKS  = kpus_pkg::KEY_FILT_TICKS,
  parameter int unsigned REG_DELAY_TICKS = kpus_pkg::REG_DELAY_TICKS,
  parameter int unsigned RAIL33_TICKS    = kpus_pkg::RAIL33_TICKS,
  parameter int unsigned OV_FILT_TICKS   = kpus_pkg::OV_FILT_TICKS
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_key_high_threshold,
  input  wire logic i_battery_not_undervoltage,
  input  wire logic i_battery_overvoltage,
  input  wire logic i_five_volt_rail_good,
  input  wire logic i_permanent_supply,
  input  wire logic i_latch_hold_request_n,
  input  wire logic i_latch_hold_not_expired,
  output logic      o_main_relay_drive,
  output logic      o_bias_enable,
  output logic      o_five_volt_rail,
  output logic      o_sensor_tracking_supplies,
  output logic      o_three_volt_rail,
  output logic      o_internal_enable
);
  localparam int unsigned W = kpus_pkg::CNT_W;

  typedef enum logic [2:0] {
    KPUS_OFF, KPUS_RELAY, KPUS_BIAS, KPUS_RAIL5, KPUS_RAIL3, KPUS_SHUT
  } kpus_state_t;

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // two-flop synchronisers for the analog comparator and pin inputs
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign sync_in = {i_key_high_threshold, i_battery_not_undervoltage,
                    i_battery_overvoltage, i_five_volt_rail_good,
                    i_permanent_supply, i_latch_hold_request_n,
                    i_latch_hold_not_expired};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic key_s, bat_ok_s, ov_s, rail5_s, perm_s, hold_n_s, hold_ok_s;
  assign {key_s, bat_ok_s, ov_s, rail5_s, perm_s, hold_n_s, hold_ok_s} = sync2_reg;

  // internal oscillator tick, free running from key-pin supply
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic       tick;
  always_comb begin
    div_next = div_reg + 8'h01;
    if (div_reg == 8'(kpus_pkg::OSC_DIV - 1)) div_next = 8'h00;
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) div_reg <= 8'h00;
    else div_reg <= div_next;
  end
  assign tick = (div_reg == 8'(kpus_pkg::OSC_DIV - 1));

  // filtered key and overvoltage levels
  logic key_filt;
  logic ov_filt;
  kpus_filter #(.CNT_W(W)) u_key_filt (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_tick  (tick),
    .i_level (key_s),
    .i_limit (W'(KEY_FILT_TICKS)),
    .o_qual  (key_filt)
  );
  kpus_filter #(.CNT_W(W)) u_ov_filt (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_tick  (tick),
    .i_level (ov_s),
    .i_limit (W'(OV_FILT_TICKS)),
    .o_qual  (ov_filt)
  );

  // internal enable from key or unexpired latch-hold
  logic en_int;
  assign en_int = bat_ok_s && (key_filt || (!hold_n_s && hold_ok_s));

  // sequencer state and delay counter
  kpus_state_t st_reg, st_next;
  logic [W-1:0] dly_reg, dly_next;
  logic         perm_bias;
  assign perm_bias = perm_s && key_s;

  always_comb begin
    st_next  = st_reg;
    dly_next = dly_reg;
    case (st_reg)
      KPUS_OFF: begin
        dly_next = '0;
        if (key_filt) st_next = perm_s ? KPUS_BIAS : KPUS_RELAY;
      end
      KPUS_RELAY: begin
        if (bat_ok_s) st_next = KPUS_BIAS;
      end
      KPUS_BIAS: begin
        if (tick) begin
          if (dly_reg >= W'(REG_DELAY_TICKS - 1)) begin
            st_next  = KPUS_RAIL5;
            dly_next = '0;
          end else dly_next = dly_reg + 1'b1;
        end
      end
      KPUS_RAIL5: begin
        if (!rail5_s) dly_next = '0;
        else if (tick) begin
          if (dly_reg >= W'(RAIL33_TICKS - 1)) st_next = KPUS_RAIL3;
          else dly_next = dly_reg + 1'b1;
        end
      end
      KPUS_RAIL3: st_next = KPUS_RAIL3;
      KPUS_SHUT: begin
        dly_next = '0;
        if (!key_s && !ov_filt) st_next = KPUS_OFF;
      end
      default: st_next = KPUS_OFF;
    endcase
    if (ov_filt) st_next = KPUS_SHUT;
    else if (st_reg != KPUS_OFF && st_reg != KPUS_SHUT && !en_int && !perm_s
             && st_reg != KPUS_RELAY)
      st_next = KPUS_OFF;
    else if (st_reg != KPUS_SHUT && st_reg != KPUS_OFF && !key_filt && !perm_s
             && st_reg == KPUS_RELAY)
      st_next = KPUS_OFF;
    else if (perm_s && st_reg != KPUS_SHUT && st_reg != KPUS_OFF && !en_int)
      st_next = KPUS_OFF;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg  <= KPUS_OFF;
      dly_reg <= '0;
    end else begin
      st_reg  <= st_next;
      dly_reg <= dly_next;
    end
  end

  // output enables registered from next state; bias also from permanent key, internal enable from en_int
  logic relay_reg, bias_reg, rail5_reg, rail3_reg, en_reg;
  logic relay_next, bias_next, rail5_next, rail3_next;
  always_comb begin
    relay_next = (st_next != KPUS_OFF) && (st_next != KPUS_SHUT);
    bias_next  = (st_next == KPUS_BIAS) || (st_next == KPUS_RAIL5) ||
                 (st_next == KPUS_RAIL3) ||
                 (perm_bias && st_next != KPUS_SHUT);
    rail5_next = (st_next == KPUS_RAIL5) || (st_next == KPUS_RAIL3);
    rail3_next = (st_next == KPUS_RAIL3);
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_reg <= 1'b0;
      bias_reg  <= 1'b0;
      rail5_reg <= 1'b0;
      rail3_reg <= 1'b0;
      en_reg    <= 1'b0;
    end else begin
      relay_reg <= relay_next;
      bias_reg  <= bias_next;
      rail5_reg <= rail5_next;
      rail3_reg <= rail3_next;
      en_reg    <= en_int;
    end
  end

  assign o_main_relay_drive         = relay_reg;
  assign o_bias_enable              = bias_reg;
  assign o_five_volt_rail           = rail5_reg;
  assign o_sensor_tracking_supplies = rail5_reg;
  assign o_three_volt_rail          = rail3_reg;
  assign o_internal_enable          = en_reg;

  // checks
  chk_relay_first: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_bias_enable) && !perm_s |-> o_main_relay_drive)
    else $error("bias enabled before relay drive");
  chk_key_filter: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_main_relay_drive) |-> key_filt)
    else $error("switched on without filtered key");
  chk_bias_bat: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_bias_enable) && !perm_s |-> bat_ok_s)
    else $error("bias without battery release");
  chk_rail5_bias: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_five_volt_rail |-> o_bias_enable)
    else $error("five volt rail without bias");
  chk_rail3_order: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_three_volt_rail) |-> $past(o_five_volt_rail, 2))
    else $error("three volt rail too early");
  chk_track_rail5: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_sensor_tracking_supplies == o_five_volt_rail &&
    o_sensor_tracking_supplies == (st_reg == KPUS_RAIL5 || st_reg == KPUS_RAIL3))
    else $error("tracking supplies differ from rail");
  chk_perm_bias: assert property (@(posedge i_clk) disable iff (!rst_n)
    perm_s && key_s && !ov_filt && st_reg != KPUS_SHUT |=> o_bias_enable)
    else $error("permanent bias missing");
  chk_ov_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    ov_filt |=> ##1 !o_five_volt_rail && !o_main_relay_drive)
    else $error("overvoltage did not switch off");
  chk_int_en: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_internal_enable |-> $past(bat_ok_s))
    else $error("enable while undervoltage");
  cov_full_up: cover property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_three_volt_rail));
  cov_perm: cover property (@(posedge i_clk) disable iff (!rst_n)
    perm_s && $rose(o_five_volt_rail));
  cov_ov: cover property (@(posedge i_clk) disable iff (!rst_n)
    st_reg == KPUS_SHUT);
endmodule : kpus_sequencer

// ===== test/kpus_supply_model.sv
// Purpose: battery pin and five volt rail-good model facing the sequencer
// Assumes: the relay closes the battery line, the rail settles after a while
// Notes:   i_slow stretches both settle times
`timescale 1ns/100ps
module kpus_supply_model (
  input  wire logic i_clk,
  input  wire logic i_slow,
  input  wire logic i_permanent_supply,
  input  wire logic i_main_relay_drive,
  input  wire logic i_five_volt_rail,
  output logic      o_battery_not_undervoltage,
  output logic      o_five_volt_rail_good
);
  int unsigned bat_cnt;
  int unsigned rail_cnt;
  // settle counters restart whenever the source drops
  always_ff @(posedge i_clk) begin
    bat_cnt  <= i_main_relay_drive ? bat_cnt + 1 : 0;
    rail_cnt <= i_five_volt_rail ? rail_cnt + 1 : 0;
  end
  // battery good once relay settled, always when permanent
  assign o_battery_not_undervoltage = i_permanent_supply | (bat_cnt >= (i_slow ? 400 : 30));
  assign o_five_volt_rail_good      = rail_cnt >= (i_slow ? 400 : 30);
endmodule : kpus_supply_model

// ===== test/key_power_up_sequencer_tb.sv
// Purpose: self-checking bench of the key power-up sequencer
// Assumes: short tick counts, oscillator tick every 100 clocks
// Notes:   output vector is relay, bias, five, tracking, three
`timescale 1ns/100ps
module key_power_up_sequencer_tb;
  typedef struct {logic [4:0] vec; int lo; int hi;} kpus_note_t;
  localparam int T = 100;
  localparam int KF = 6;
  localparam int RD = 4;
  localparam int R3 = 5;
  localparam int OV = 4;
  logic i_clk = 1'b0, i_reset_n = 1'b0, key = 1'b0, bat_ok, ov = 1'b0, rail_ok;
  logic perm = 1'b0, hold_n = 1'b1, hold_ok = 1'b0, slow = 1'b1;
  logic relay, bias, five, track, three, int_en;
  logic [4:0] now_vec, prev_vec = 5'h00;
  kpus_note_t notes[$];
  kpus_note_t nt;
  int errors = 0, checks = 0, cyc = 0, base = 0, lat;
  bit run = 1'b0;

  kpus_sequencer #(.KEY_FILT_TICKS(KF), .REG_DELAY_TICKS(RD), .RAIL33_TICKS(R3),
    .OV_FILT_TICKS(OV)) kpus_sequencer_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_key_high_threshold(key),
    .i_battery_not_undervoltage(bat_ok), .i_battery_overvoltage(ov),
    .i_five_volt_rail_good(rail_ok), .i_permanent_supply(perm),
    .i_latch_hold_request_n(hold_n), .i_latch_hold_not_expired(hold_ok),
    .o_main_relay_drive(relay), .o_bias_enable(bias), .o_five_volt_rail(five),
    .o_sensor_tracking_supplies(track), .o_three_volt_rail(three),
    .o_internal_enable(int_en));
  kpus_supply_model kpus_supply_model_i (
    .i_clk(i_clk), .i_slow(slow), .i_permanent_supply(perm),
    .i_main_relay_drive(relay), .i_five_volt_rail(five),
    .o_battery_not_undervoltage(bat_ok), .o_five_volt_rail_good(rail_ok));

  // clock, 10 ns period
  always #5 i_clk = ~i_clk;

  task automatic wrap_up;
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chk

  task automatic note_raw(input logic [4:0] v, input int lo, input int hi);
    notes.push_back('{v, lo, hi});
  endtask : note_raw

  // window of n ticks plus or minus one tick
  task automatic note(input logic [4:0] v, input int n, input int extra);
    note_raw(v, (n - 1) * T + extra, (n + 1) * T + extra + 10);
  endtask : note

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : idle

  // bounded wait until every note has been met
  task automatic drain;
    for (int i = 0; i < 9000; i++) begin
      if (notes.size() == 0) return;
      idle(1);
    end
    chk(notes.size(), 0);
    wrap_up();
  endtask : drain

  // monitor: every output change consumes the oldest note
  always @(negedge i_clk) begin
    cyc++;
    now_vec = {relay, bias, five, track, three};
    if (run && now_vec !== prev_vec) begin
      if (notes.size() == 0) begin
        chk(now_vec, prev_vec);
      end else begin
        nt = notes.pop_front();
        chk(now_vec, nt.vec);
        chk((cyc - base >= nt.lo) && (cyc - base <= nt.hi), 1);
      end
      base = cyc;
      prev_vec = now_vec;
    end
  end

  // main sequence
  initial begin
    void'($urandom(57679));
    idle(2);
    i_reset_n = 1'b1;
    idle(3);
    run = 1'b1;
    lat = 400;
    // glitch shorter than the filter must do nothing
    key = 1'b1;
    idle($urandom_range(KF - 2, 1) * T);
    key = 1'b0;
    idle(3 * T);
    // non-permanent power-up with a slow battery
    note(5'h10, KF, 0);
    note_raw(5'h18, lat, lat + 10);
    note(5'h1e, RD, 0);
    note(5'h1f, R3, lat);
    key = 1'b1;
    base = cyc;
    drain();
    chk(int_en, 1);
    // latch hold keeps everything up after key low
    hold_n = 1'b0;
    hold_ok = 1'b1;
    key = 1'b0;
    idle((KF + 3) * T);
    chk(int_en, 1);
    note_raw(5'h00, 0, 10);
    hold_ok = 1'b0;
    base = cyc;
    drain();
    chk(int_en, 0);
    hold_n = 1'b1;
    // permanent supply, prompt rails
    slow = 1'b0;
    perm = 1'b1;
    idle(2 * T);
    note_raw(5'h08, 1, 8);
    note(5'h18, KF, -6);
    note(5'h1e, RD, 0);
    note(5'h1f, R3, 30);
    key = 1'b1;
    base = cyc;
    drain();
    // short overvoltage ignored, long one shuts down
    ov = 1'b1;
    idle($urandom_range(OV - 2, 1) * T);
    ov = 1'b0;
    idle(2 * T);
    note(5'h00, OV, 0);
    ov = 1'b1;
    base = cyc;
    drain();
    key = 1'b0;
    ov = 1'b0;
    idle((KF + 2) * T);
    wrap_up();
  end
endmodule : key_power_up_sequencer_tb
